// [core/asmr_top.sv]
// serially programmed mode register bank with output formatting
//
// Function
// - frame: flag, seven address bits, eight data
// - flag zero writes data to addressed register
// - flag one reads register, no update
// - serial output only pulls low or releases
// - reset bit clears registers, brief sleep
// - reset bit clears itself after write frame
// - reset register write-only, reads return zero
// - format bit 7 disables duty stabilizer
// - format bit 6 enables output scrambler
// - format bit 5 selects signed coding
// - format bits 4,3,0 sleep and naps
// - output bits 7-5 select drive current
// - termination enable doubles drive current
// - output bit 3 disables digital outputs
// - output bit 2 forces fixed pattern
// - output bits 1-0 select lane count
// - pattern registers give high, low bytes
// - frame from select low, sixteen edges counted
// - scrambler xors lsb into other bits
// - fixed pattern overrides coding and scrambler
`timescale 1ns/1ps
module asmr_top #(
    parameter int SLEEP_CYC = asmr_pkg::SOFT_SLEEP_CYC
) (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic SCK,
    input wire logic CS_N,
    input wire logic SDI,
    output logic SDO_O,
    output logic SDO_OE,
    input wire logic PROGRAM_STYLE_SELECT,
    input wire logic [asmr_pkg::SMP_W-1:0] DATA_CH1_IN,
    input wire logic [asmr_pkg::SMP_W-1:0] DATA_CH2_IN,
    output logic [asmr_pkg::SMP_W-1:0] DATA_CH1_OUT,
    output logic [asmr_pkg::SMP_W-1:0] DATA_CH2_OUT,
    output logic SERIAL_MODE,
    output logic DUTY_STABILIZER_DISABLE,
    output logic OUTPUT_SCRAMBLE_ENABLE,
    output logic SIGNED_CODING_SELECT,
    output logic CH1_NAP,
    output logic CH2_NAP,
    output logic SLEEP_ALL,
    output logic [2:0] DRIVE_CURRENT_CODE,
    output logic INTERNAL_TERMINATION_ENABLE,
    output logic [7:0] DRIVE_CURRENT_UNITS,
    output logic OUTPUTS_DISABLE,
    output logic FIXED_PATTERN_ENABLE,
    output logic [1:0] LANE_COUNT_SELECT,
    output logic [2:0] LANE_COUNT,
    output logic [asmr_pkg::SMP_W-1:0] PATTERN_WORD
);
    import asmr_pkg::*;

    typedef struct packed {
        logic rst_hold;
        logic t1;
        logic t2;
        logic t3;
        logic p1;
        logic p2;
        logic [NUM_REG-1:0][DATA_W-1:0] rg;
        logic [4:0] slp_cnt;
        logic sleep;
        logic [7:0] cur;
        logic [2:0] lanes;
        logic [NUM_CH-1:0][SMP_W-1:0] dout;
    } asmr_state_s;

    asmr_state_s st_ff, nxt_st;
    logic sdo_oe_link;
    logic frm_tgl_link;
    logic [WORD_W-1:0] frm_word_link;
    logic [NUM_CH-1:0][SMP_W-1:0] din;
    logic [NUM_CH-1:0][SMP_W-1:0] fmt_word;
    logic [NUM_CH-1:0] ch_off;
    logic [SMP_W-1:0] pattern;
    logic [DATA_W-1:0] fmt_reg;
    logic [DATA_W-1:0] out_reg;
    logic frame_new;
    logic [ADDR_W-1:0] w_addr;
    logic [DATA_W-1:0] w_data;
    logic [1:0] w_idx;
    logic [2:0] cur_code;
    logic [7:0] cur_base;

    // link side: runs on the serial clock, returns finished frames
    asmr_serial_port u_port (
        .sck(SCK),
        .cs_n(CS_N),
        .sdi(SDI),
        .mode_serial(~st_ff.p2),
        .rst_hold(st_ff.rst_hold),
        .sdo_oe(sdo_oe_link),
        .frm_tgl(frm_tgl_link),
        .frm_word(frm_word_link)
    );

    // current register views
    assign fmt_reg = st_ff.rg[IDX_FORMAT];
    assign out_reg = st_ff.rg[IDX_OUTPUT];
    assign pattern = {st_ff.rg[IDX_PAT_HI], st_ff.rg[IDX_PAT_LO]};
    assign din = {DATA_CH2_IN, DATA_CH1_IN};
    assign ch_off[0] = fmt_reg[FMT_NAP1_BIT] | st_ff.sleep;
    assign ch_off[1] = fmt_reg[FMT_NAP2_BIT] | st_ff.sleep;

    // output word formatting for each channel
    genvar c;
    generate
        for (c = 0; c < NUM_CH; c++) begin : g_ch
            logic [SMP_W-1:0] coded;
            logic [SMP_W-1:0] mixed;
            // offset binary to two's complement flips the msb
            assign coded = fmt_reg[FMT_SGN_BIT] ?
                {~din[c][SMP_W-1], din[c][SMP_W-2:0]} : din[c];
            // lsb goes into every other bit, lsb itself unchanged
            assign mixed = fmt_reg[FMT_SCR_BIT] ?
                {coded[SMP_W-1:1] ^ {(SMP_W-1){coded[0]}}, coded[0]}
                : coded;
            // pattern wins over coding and scrambling
            assign fmt_word[c] = ch_off[c] ? '0 :
                out_reg[OUT_TEST_BIT] ? pattern : mixed;
        end
    endgenerate

    // decode of a frame handed over by the link side
    assign frame_new = st_ff.t2 ^ st_ff.t3;
    assign w_addr = frm_word_link[ADDR_HI:ADDR_LO];
    assign w_data = frm_word_link[DATA_W-1:0];
    assign w_idx = 2'(w_addr - 7'h01);

    // next state of the system clock side
    always_comb begin
        nxt_st = st_ff;
        nxt_st.rst_hold = 1'b0;
        nxt_st.t1 = frm_tgl_link;
        nxt_st.t2 = st_ff.t1;
        nxt_st.t3 = st_ff.t2;
        nxt_st.p1 = PROGRAM_STYLE_SELECT;
        nxt_st.p2 = st_ff.p1;
        if (st_ff.slp_cnt != 5'h00) begin
            nxt_st.slp_cnt = st_ff.slp_cnt - 5'h01;
        end
        // reads leave the bank alone; only write frames land here
        if (frame_new && !frm_word_link[RW_BIT] && !st_ff.p2) begin
            if (w_addr == ADDR_RESET) begin
                // reset bit is never stored, so it reads back clear
                if (w_data[RST_BIT]) begin
                    nxt_st.rg = '0;
                    nxt_st.slp_cnt = 5'(SLEEP_CYC);
                end
            end else if (w_addr <= ADDR_PAT_LO) begin
                nxt_st.rg[w_idx] = w_data;
            end
        end
        nxt_st.sleep = nxt_st.rg[IDX_FORMAT][FMT_SLEEP_BIT] |
            (nxt_st.slp_cnt != 5'h00);
        // drive current lookup for the next output register value
        cur_code = nxt_st.rg[IDX_OUTPUT][OUT_CUR_HI:OUT_CUR_LO];
        case (cur_code)
            3'h0: cur_base = CUR_3P5;
            3'h1: cur_base = CUR_4P0;
            3'h2: cur_base = CUR_4P5;
            3'h4: cur_base = CUR_3P0;
            3'h5: cur_base = CUR_2P5;
            3'h6: cur_base = CUR_2P1;
            3'h7: cur_base = CUR_1P75;
            default: cur_base = CUR_NONE;
        endcase
        nxt_st.cur = nxt_st.rg[IDX_OUTPUT][OUT_TERM_BIT] ?
            8'(cur_base << 1) : cur_base;
        case (nxt_st.rg[IDX_OUTPUT][OUT_LANE_HI:OUT_LANE_LO])
            LANE_CODE_2: nxt_st.lanes = LANES_2;
            LANE_CODE_4: nxt_st.lanes = LANES_4;
            LANE_CODE_1: nxt_st.lanes = LANES_1;
            default: nxt_st.lanes = LANES_NONE;
        endcase
        nxt_st.dout = fmt_word;
        if (SRST) begin
            nxt_st = '0;
            nxt_st.rst_hold = 1'b1;
            nxt_st.rg = {NUM_REG{REG_RESET_VAL}};
            nxt_st.cur = CUR_3P5;
            nxt_st.lanes = LANES_2;
        end
    end

    // single state register of the system clock side
    always_ff @(posedge MCLK) begin
        st_ff <= nxt_st;
    end

    // open drain: the pin is only ever pulled low
    assign SDO_O = 1'b0;
    assign SDO_OE = sdo_oe_link;

    // control outputs straight from the register flops
    assign SERIAL_MODE = ~st_ff.p2;
    assign DUTY_STABILIZER_DISABLE = fmt_reg[FMT_DCS_BIT];
    assign OUTPUT_SCRAMBLE_ENABLE = fmt_reg[FMT_SCR_BIT];
    assign SIGNED_CODING_SELECT = fmt_reg[FMT_SGN_BIT];
    assign CH1_NAP = fmt_reg[FMT_NAP1_BIT];
    assign CH2_NAP = fmt_reg[FMT_NAP2_BIT];
    assign SLEEP_ALL = st_ff.sleep;
    assign DRIVE_CURRENT_CODE = out_reg[OUT_CUR_HI:OUT_CUR_LO];
    assign INTERNAL_TERMINATION_ENABLE = out_reg[OUT_TERM_BIT];
    assign DRIVE_CURRENT_UNITS = st_ff.cur;
    assign OUTPUTS_DISABLE = out_reg[OUT_OFF_BIT];
    assign FIXED_PATTERN_ENABLE = out_reg[OUT_TEST_BIT];
    assign LANE_COUNT_SELECT = out_reg[OUT_LANE_HI:OUT_LANE_LO];
    assign LANE_COUNT = st_ff.lanes;
    assign PATTERN_WORD = pattern;

    // data outputs are held low while the drivers are off
    assign DATA_CH1_OUT = out_reg[OUT_OFF_BIT] ? '0 : st_ff.dout[0];
    assign DATA_CH2_OUT = out_reg[OUT_OFF_BIT] ? '0 : st_ff.dout[1];

endmodule : asmr_top

// [core/asmr_pkg.sv]
// constants and types shared by the serial mode register bank
package asmr_pkg;

    // frame layout
    localparam int ADDR_W = 7;
    localparam int DATA_W = 8;
    localparam int WORD_W = 16;
    localparam int SMP_W = 16;
    localparam int NUM_CH = 2;
    localparam int NUM_REG = 4;
    localparam logic [4:0] LAST_HDR_EDGE = 5'h07;
    localparam logic [4:0] LAST_FRM_EDGE = 5'h0F;
    localparam int RW_BIT = 15;
    localparam int ADDR_HI = 14;
    localparam int ADDR_LO = 8;

    // register addresses
    localparam logic [6:0] ADDR_RESET = 7'h00;
    localparam logic [6:0] ADDR_FORMAT = 7'h01;
    localparam logic [6:0] ADDR_PAT_LO = 7'h04;
    localparam logic [1:0] IDX_FORMAT = 2'h0;
    localparam logic [1:0] IDX_OUTPUT = 2'h1;
    localparam logic [1:0] IDX_PAT_HI = 2'h2;
    localparam logic [1:0] IDX_PAT_LO = 2'h3;
    localparam logic [7:0] REG_RESET_VAL = 8'h00;
    localparam logic [7:0] RESET_READ_VAL = 8'h00;

    // field positions
    localparam int RST_BIT = 7;
    localparam int FMT_DCS_BIT = 7;
    localparam int FMT_SCR_BIT = 6;
    localparam int FMT_SGN_BIT = 5;
    localparam int FMT_SLEEP_BIT = 4;
    localparam int FMT_NAP2_BIT = 3;
    localparam int FMT_NAP1_BIT = 0;
    localparam int OUT_CUR_HI = 7;
    localparam int OUT_CUR_LO = 5;
    localparam int OUT_TERM_BIT = 4;
    localparam int OUT_OFF_BIT = 3;
    localparam int OUT_TEST_BIT = 2;
    localparam int OUT_LANE_HI = 1;
    localparam int OUT_LANE_LO = 0;

    // drive current in units of 0.05 mA
    localparam logic [7:0] CUR_3P5 = 8'h46;
    localparam logic [7:0] CUR_4P0 = 8'h50;
    localparam logic [7:0] CUR_4P5 = 8'h5A;
    localparam logic [7:0] CUR_3P0 = 8'h3C;
    localparam logic [7:0] CUR_2P5 = 8'h32;
    localparam logic [7:0] CUR_2P1 = 8'h2A;
    localparam logic [7:0] CUR_1P75 = 8'h23;
    localparam logic [7:0] CUR_NONE = 8'h00;

    // lane modes
    localparam logic [1:0] LANE_CODE_2 = 2'h0;
    localparam logic [1:0] LANE_CODE_4 = 2'h1;
    localparam logic [1:0] LANE_CODE_1 = 2'h2;
    localparam logic [2:0] LANES_1 = 3'h1;
    localparam logic [2:0] LANES_2 = 3'h2;
    localparam logic [2:0] LANES_4 = 3'h4;
    localparam logic [2:0] LANES_NONE = 3'h0;

    // timing
    localparam int CLK_PERIOD_PS = 5000;
    localparam int SOFT_SLEEP_NS = 100;
    localparam int SOFT_SLEEP_CYC =
        (SOFT_SLEEP_NS * 1000 + CLK_PERIOD_PS - 1) / CLK_PERIOD_PS;

    // serial frame phases
    typedef enum logic [2:0] {
        PH_HDR = 3'b001,
        PH_DAT = 3'b010,
        PH_END = 3'b100
    } asmr_phase_e;

endpackage : asmr_pkg

// [core/asmr_serial_port.sv]
// serial clock side: frame shifter, register mirror and read-back
`timescale 1ns/1ps
module asmr_serial_port (
    input wire logic sck,
    input wire logic cs_n,
    input wire logic sdi,
    input wire logic mode_serial,
    input wire logic rst_hold,
    output logic sdo_oe,
    output logic frm_tgl,
    output logic [asmr_pkg::WORD_W-1:0] frm_word
);
    import asmr_pkg::*;

    typedef struct packed {
        asmr_phase_e ph;
        logic [4:0] cnt;
        logic [WORD_W-1:0] shf;
        logic [DATA_W-1:0] tx;
        logic rd;
        logic oe;
    } asmr_frm_s;

    typedef struct packed {
        logic [NUM_REG-1:0][DATA_W-1:0] mir;
        logic tgl;
        logic [WORD_W-1:0] word;
        logic m1;
        logic m2;
    } asmr_mir_s;

    asmr_frm_s frm_ff, nxt_frm;
    asmr_mir_s mir_ff, nxt_mir;
    logic [WORD_W-1:0] full;
    logic [ADDR_W-1:0] addr;
    logic [1:0] idx;

    // next frame and mirror state for each rising serial clock edge
    always_comb begin
        nxt_frm = frm_ff;
        nxt_mir = mir_ff;
        nxt_mir.m1 = mode_serial;
        nxt_mir.m2 = mir_ff.m1;
        full = {frm_ff.shf[WORD_W-2:0], sdi};
        addr = full[ADDR_W-1:0];
        idx = 2'(addr - 7'h01);
        if (frm_ff.ph != PH_END) begin
            nxt_frm.shf = full;
            nxt_frm.cnt = frm_ff.cnt + 5'h01;
            nxt_frm.tx = {frm_ff.tx[DATA_W-2:0], 1'b0};
            nxt_frm.oe = frm_ff.rd & ~frm_ff.tx[DATA_W-2];
        end
        if (frm_ff.ph == PH_HDR && frm_ff.cnt == LAST_HDR_EDGE) begin
            nxt_frm.ph = PH_DAT;
            nxt_frm.rd = full[ADDR_W] & mir_ff.m2;
            if (addr >= ADDR_FORMAT && addr <= ADDR_PAT_LO) begin
                nxt_frm.tx = mir_ff.mir[idx];
            end else begin
                nxt_frm.tx = RESET_READ_VAL;
            end
            nxt_frm.oe = full[ADDR_W] & mir_ff.m2 & ~nxt_frm.tx[DATA_W-1];
        end
        if (frm_ff.ph == PH_DAT && frm_ff.cnt == LAST_FRM_EDGE) begin
            nxt_frm.ph = PH_END;
            nxt_frm.oe = 1'b0;
            nxt_mir.word = full;
            nxt_mir.tgl = ~mir_ff.tgl;
            idx = 2'(full[ADDR_HI:ADDR_LO] - 7'h01);
            if (!full[RW_BIT] && mir_ff.m2) begin
                if (full[ADDR_HI:ADDR_LO] == ADDR_RESET) begin
                    if (full[RST_BIT]) begin
                        nxt_mir.mir = '0;
                    end
                end else if (full[ADDR_HI:ADDR_LO] <= ADDR_PAT_LO) begin
                    nxt_mir.mir[idx] = full[DATA_W-1:0];
                end
            end
        end
    end

    // frame state is cleared while chip select is high
    always_ff @(posedge sck or posedge cs_n) begin
        if (cs_n) begin
            frm_ff <= '{ph: PH_HDR, cnt: 5'h00, shf: 16'h0000,
                        tx: 8'h00, rd: 1'b0, oe: 1'b0};
        end else begin
            frm_ff <= nxt_frm;
        end
    end

    // mirror survives frames and clears on the block reset or a reset-bit write
    always_ff @(posedge sck or posedge rst_hold) begin
        if (rst_hold) begin
            mir_ff <= '0;
        end else begin
            mir_ff <= nxt_mir;
        end
    end

    assign sdo_oe = frm_ff.oe;
    assign frm_tgl = mir_ff.tgl;
    assign frm_word = mir_ff.word;

endmodule : asmr_serial_port

// [dv/asmr_top_asserts.sv]
// port checker for the serial mode register bank
`timescale 1ns/1ps
module asmr_top_asserts (
    input wire logic MCLK,
    input wire logic SRST,
    input wire logic CS_N,
    input wire logic SDO_O,
    input wire logic SDO_OE,
    input wire logic PROGRAM_STYLE_SELECT,
    input wire logic [asmr_pkg::SMP_W-1:0] DATA_CH1_IN,
    input wire logic [asmr_pkg::SMP_W-1:0] DATA_CH2_IN,
    input wire logic [asmr_pkg::SMP_W-1:0] DATA_CH1_OUT,
    input wire logic [asmr_pkg::SMP_W-1:0] DATA_CH2_OUT,
    input wire logic SERIAL_MODE,
    input wire logic OUTPUT_SCRAMBLE_ENABLE,
    input wire logic SIGNED_CODING_SELECT,
    input wire logic CH1_NAP,
    input wire logic CH2_NAP,
    input wire logic SLEEP_ALL,
    input wire logic [2:0] DRIVE_CURRENT_CODE,
    input wire logic INTERNAL_TERMINATION_ENABLE,
    input wire logic [7:0] DRIVE_CURRENT_UNITS,
    input wire logic OUTPUTS_DISABLE,
    input wire logic FIXED_PATTERN_ENABLE,
    input wire logic [1:0] LANE_COUNT_SELECT,
    input wire logic [2:0] LANE_COUNT,
    input wire logic [asmr_pkg::SMP_W-1:0] PATTERN_WORD
);
    import asmr_pkg::*;
    localparam logic [7:0] CUR_T [8] = '{8'h46, 8'h50, 8'h5A, 8'h00,
        8'h3C, 8'h32, 8'h2A, 8'h23};
    localparam logic [2:0] LN_T [4] = '{3'h2, 3'h4, 3'h1, 3'h0};
    logic [15:0] exp1_ff, exp2_ff;
    logic [1:0] off_ff;
    default clocking cb @(posedge MCLK); endclocking
    default disable iff (SRST);

    // expected sample: coding, then scrambler, pattern wins
    function automatic logic [15:0] fmt(input logic [15:0] d);
        logic [15:0] v;
        v = d ^ {SIGNED_CODING_SELECT, 15'h0000};
        if (OUTPUT_SCRAMBLE_ENABLE) v[15:1] = v[15:1] ^ {15{v[0]}};
        return FIXED_PATTERN_ENABLE ? PATTERN_WORD : v;
    endfunction : fmt

    // one-cycle model of the sample path and its blanking causes
    always_ff @(posedge MCLK) begin
        exp1_ff <= fmt(DATA_CH1_IN);
        exp2_ff <= fmt(DATA_CH2_IN);
        off_ff <= {CH2_NAP | SLEEP_ALL | SRST, CH1_NAP | SLEEP_ALL | SRST};
    end

    a_sdo_low_only: assert property (!SDO_O)
        else $error("serial output driven high");
    a_oe_idle_off: assert property (CS_N && $past(CS_N) |-> !SDO_OE)
        else $error("serial output pulled while deselected");
    a_cur_units: assert property ($stable(DRIVE_CURRENT_CODE) &&
        $stable(INTERNAL_TERMINATION_ENABLE) |-> DRIVE_CURRENT_UNITS ==
        (CUR_T[DRIVE_CURRENT_CODE] << INTERNAL_TERMINATION_ENABLE))
        else $error("drive current wrong");
    a_lane_units: assert property ($stable(LANE_COUNT_SELECT) |->
        LANE_COUNT == LN_T[LANE_COUNT_SELECT]) else $error("lane count wrong");
    a_outs_zero: assert property (OUTPUTS_DISABLE |->
        DATA_CH1_OUT == 16'h0000 && DATA_CH2_OUT == 16'h0000)
        else $error("disabled outputs not zero");
    a_ch1_format: assert property (
        !off_ff[0] && !CH1_NAP &&
        !SLEEP_ALL && !OUTPUTS_DISABLE |-> DATA_CH1_OUT == exp1_ff)
        else $error("channel 1 sample wrong");
    a_ch2_format: assert property (
        !off_ff[1] && !CH2_NAP &&
        !SLEEP_ALL && !OUTPUTS_DISABLE |-> DATA_CH2_OUT == exp2_ff)
        else $error("channel 2 sample wrong");
    a_nap_zero: assert property ($past(CH1_NAP) |->
        DATA_CH1_OUT == 16'h0000) else $error("napped channel not zero");
    a_mode_par: assert property (PROGRAM_STYLE_SELECT[*5] |=>
        !SERIAL_MODE) else $error("serial mode in parallel style");
    a_mode_ser: assert property ((!PROGRAM_STYLE_SELECT)[*5] |=>
        SERIAL_MODE) else $error("serial mode missing");
    a_regs_idle: assert property (CS_N[*8] |->
        $stable(PATTERN_WORD) && $stable(LANE_COUNT_SELECT))
        else $error("register moved outside frame");
endmodule : asmr_top_asserts

bind asmr_top asmr_top_asserts u_chk (.*);

// [dv/asmr_host.sv]
// serial master model on the host side of the register port
`timescale 1ns/1ps
module asmr_host (
    output logic sck,
    output logic cs_n,
    output logic sdi,
    input wire logic sdo
);
    // clock stands low and select high between frames
    initial begin
        sck = 1'b0;
        cs_n = 1'b1;
        sdi = 1'b0;
    end
    // clock edges with select high let the mode sync fill
    task automatic idle(input int n);
        repeat (n) begin
            #62.5 sck = 1'b1;
            #62.5 sck = 1'b0;
        end
    endtask : idle
    // frame of n edges, data msb first, changed after each falling edge
    task automatic xfer(input logic [15:0] w, input int n,
        output logic [7:0] rd);
        rd = 8'h00;
        #37 cs_n = 1'b0;
        for (int i = 0; i < n; i++) begin
            sdi = (i < 16) ? w[15-i] : ~sdi;
            #62.5;
            if (i >= 8 && i < 16) rd[15-i] = sdo;
            sck = 1'b1;
            #62.5 sck = 1'b0;
        end
        sdi = ~sdi; // released line shows no stale bit
        #40 cs_n = 1'b1;
        #40;
    endtask : xfer
endmodule : asmr_host

// [dv/asmr_top_tb_top.sv]
// self-checking bench for the serial mode register bank
`timescale 1ns/1ps
module asmr_top_tb_top;
    import asmr_pkg::*;
    localparam logic [7:0] CUR_T [8] = '{8'h46, 8'h50, 8'h5A, 8'h00,
        8'h3C, 8'h32, 8'h2A, 8'h23};
    localparam logic [2:0] LN_T [4] = '{3'h2, 3'h4, 3'h1, 3'h0};
    logic mclk, srst, sck, cs_n, sdi, sdo_o, sdo_oe, sdo, pss, sm, dcs;
    logic scr, sgn, n1, n2, slp, term, off, pat;
    logic [15:0] d1, d2, o1, o2, pw;
    logic [7:0] cu, rd;
    logic [2:0] cc, lc;
    logic [1:0] ls;
    int num_errors, tests_run, n;

    // open-drain wire with host pull-up; 5 ns system clock
    assign sdo = sdo_oe ? sdo_o : 1'b1;
    initial mclk = 1'b0;
    always #2.5 mclk = ~mclk;

    asmr_top #(.SLEEP_CYC(3)) u_dut (.MCLK(mclk), .SRST(srst), .SCK(sck),
        .CS_N(cs_n), .SDI(sdi), .SDO_O(sdo_o), .SDO_OE(sdo_oe),
        .PROGRAM_STYLE_SELECT(pss), .DATA_CH1_IN(d1), .DATA_CH2_IN(d2),
        .DATA_CH1_OUT(o1), .DATA_CH2_OUT(o2), .SERIAL_MODE(sm),
        .DUTY_STABILIZER_DISABLE(dcs), .OUTPUT_SCRAMBLE_ENABLE(scr),
        .SIGNED_CODING_SELECT(sgn), .CH1_NAP(n1), .CH2_NAP(n2),
        .SLEEP_ALL(slp), .DRIVE_CURRENT_CODE(cc),
        .INTERNAL_TERMINATION_ENABLE(term), .DRIVE_CURRENT_UNITS(cu),
        .OUTPUTS_DISABLE(off), .FIXED_PATTERN_ENABLE(pat),
        .LANE_COUNT_SELECT(ls), .LANE_COUNT(lc), .PATTERN_WORD(pw));
    asmr_host u_host (.sck(sck), .cs_n(cs_n), .sdi(sdi), .sdo(sdo));

    // compare and count
    task automatic chk(input string nm, input logic [15:0] e,
        input logic [15:0] s);
        tests_run++;
        if (s !== e) begin
            num_errors++;
            $display("mismatch %s expected %h seen %h", nm, e, s);
        end
    endtask : chk
    // one frame, then settle on the system clock
    task automatic frm(input int rw, input logic [6:0] a,
        input logic [7:0] d, input int e = 16);
        u_host.xfer({rw[0], a, d}, e, rd);
        @(negedge mclk);
    endtask : frm
    // verdict and end of run
    task automatic complete_run();
        $display("errors %0d checks %0d", num_errors, tests_run);
        if (num_errors == 0 && tests_run > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask : complete_run

    // watchdog
    initial begin
        #300000;
        num_errors++;
        complete_run();
    end

    // main sequence
    initial begin
        srst = 1'b1;
        pss = 1'b0;
        d1 = 16'h1235;
        d2 = 16'h00F0;
        repeat (5) @(negedge mclk);
        srst = 1'b0;
        repeat (4) @(negedge mclk);
        chk("cu", 8'h46, cu);
        chk("lc", 3'h2, lc);
        chk("sm", 1'b1, sm);
        u_host.idle(2);
        frm(0, ADDR_RESET, 8'h80);
        frm(0, ADDR_FORMAT, 8'h9F);
        chk("fmt", 16'h0027, {dcs, scr, sgn, slp, n2, n1});
        frm(0, ADDR_FORMAT, 8'h60);
        chk("fmt", 16'h0018, {dcs, scr, sgn, slp, n2, n1});
        chk("o1", 16'h6DCB, o1);
        chk("o2", 16'h80F0, o2);
        frm(1, ADDR_FORMAT, 8'hFF);
        chk("rd", 8'h60, rd);
        chk("kept", 1'b1, scr);
        frm(0, 7'h03, 8'hC3);
        frm(0, ADDR_PAT_LO, 8'h5A);
        chk("pw", 16'hC35A, pw);
        frm(0, 7'h02, 8'h04);
        chk("a2", 16'h0001, {off, pat});
        chk("o1", 16'hC35A, o1);
        chk("o2", 16'hC35A, o2);
        frm(0, 7'h02, 8'h08);
        chk("a2", 16'h0002, {off, pat});
        chk("o2", 16'h0000, o2);
        chk("o1", 16'h0000, o1);
        for (int k = 0; k < 16; k++) begin
            frm(0, 7'h02, {k[2:0], k[3], 2'b00, k[1:0]});
            chk("cu", CUR_T[k[2:0]] << k[3], cu);
            chk("lc", LN_T[k[1:0]], lc);
            chk("a2", {k[2:0], k[3], k[1:0]}, {cc, term, ls});
        end
        frm(0, 7'h02, 8'h00);
        frm(0, ADDR_FORMAT, 8'h01);
        chk("o1", 16'h0000, o1);
        chk("o2", 16'h00F0, o2);
        frm(0, ADDR_FORMAT, 8'h08);
        chk("o1", 16'h1235, o1);
        chk("o2", 16'h0000, o2);
        frm(0, 7'h03, 8'h00, 12);
        chk("pw", 16'hC35A, pw);
        frm(0, 7'h03, 8'h11, 20);
        chk("pw", 16'h115A, pw);
        frm(0, 7'h05, 8'hFF);
        frm(1, 7'h05, 8'h00);
        chk("rd", 8'h00, rd);
        frm(1, ADDR_RESET, 8'h00);
        chk("rd", 8'h00, rd);
        pss = 1'b1;
        repeat (8) @(negedge mclk);
        chk("sm", 1'b0, sm);
        frm(0, 7'h03, 8'h77);
        chk("pw", 16'h115A, pw);
        frm(1, 7'h03, 8'h00);
        chk("rd", 8'hFF, rd);
        pss = 1'b0;
        u_host.idle(3);
        n = 0;
        fork
            frm(0, ADDR_RESET, 8'h80);
            repeat (600) begin
                @(negedge mclk);
                if (slp === 1'b1) n++;
            end
        join
        chk("sleep", 16'h0003, n[15:0]);
        chk("pw", 16'h0000, pw);
        chk("fmt", 16'h0000, {dcs, scr, sgn, slp, n2, n1});
        frm(0, 7'h03, 8'h12);
        frm(0, ADDR_RESET, 8'h7F);
        chk("pw", 16'h1200, pw);
        for (int k = 1; k < 5; k++) begin
            frm(1, k[6:0], 8'h00);
            chk("rd", (k == 3) ? 8'h12 : 8'h00, rd);
        end
        complete_run();
    end
endmodule : asmr_top_tb_top
